// ### verilog/fcs_pkg.sv
// Constants for the host-side flash command sequencer.
// Assumes a parallel NOR flash on pins, strobes active low, 125 MHz clock.
package fcs_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
    localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa;
    localparam logic [19:0] ADDR_ID_MAKER = 20'h00000;
    localparam logic [19:0] ADDR_ID_DEVICE = 20'h00001;
    localparam logic [19:0] ADDR_ID_PROT = 20'h00002;
    localparam logic [19:0] ADDR_ANY = 20'h00000;
    localparam logic [7:0] DATA_UNLOCK1 = 8'haa;
    localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int PROT_BIT = 0;
    localparam int SECTOR_LSB = 12;
    localparam int CLK_NS = 8;
    localparam int RST_LOW_NS = 500;
    localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_WAIT_US = 20;
    localparam int READY_WAIT_CYC = READY_WAIT_US * 1000 / CLK_NS;
    localparam int RST_REC_NS = 50;
    localparam int RST_REC_CYC = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = 4;
    localparam int READ_CYC = 16;
    localparam int CNT_W = 16;
    typedef enum logic [2:0] {
        FCS_OP_READ,
        FCS_OP_PROGRAM,
        FCS_OP_ID_READ,
        FCS_OP_RESET_CMD,
        FCS_OP_BYP_ENTER,
        FCS_OP_BYP_EXIT,
        FCS_OP_HW_RESET
    } fcs_op_t;
endpackage

// ### verilog/fcs_host.sv
// Host controller driving a NOR flash through its pins.
// Assumes one user op at a time via i_req/o_ack and a word-mode part.
module fcs_host #(
    parameter int READY_WAIT = fcs_pkg::READY_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    // User side
    input  wire logic                      i_req,
    input  wire logic [2:0]                i_op,
    input  wire logic [fcs_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [fcs_pkg::DATA_W-1:0] i_wdata,
    output logic                           o_ack,
    output logic                           o_busy,
    output logic [fcs_pkg::DATA_W-1:0]     o_rdata,
    output logic                           o_err,
    output logic                           o_bypass,
    // Flash pins
    output logic [fcs_pkg::ADDR_W-1:0]     o_fl_addr,
    output logic                           o_fl_ce_b,
    output logic                           o_fl_we_b,
    output logic                           o_fl_oe_b,
    output logic                           o_fl_reset_b,
    output logic [fcs_pkg::DATA_W-1:0]     o_fl_dq,
    output logic                           o_fl_dq_oe_b,
    input  wire logic [fcs_pkg::DATA_W-1:0] i_fl_dq,
    input  wire logic                      i_ready_busy_out
);
    typedef enum {
        FCS_IDLE, FCS_WR, FCS_RD, FCS_POLL, FCS_RSTLOW, FCS_RSTWAIT,
        FCS_RSTREC, FCS_DONE
    } fcs_state_t;
    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers: second and third stage must agree
    logic [fcs_pkg::DATA_W-1:0] dq_s1, dq_s2, dq_s3, dq_q;
    logic rb_s1, rb_s2, rb_s3, rb_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dq_s3 <= '0;
            dq_q <= '0;
            rb_s1 <= 1'b0;
            rb_s2 <= 1'b0;
            rb_s3 <= 1'b0;
            rb_q <= 1'b0;
        end else begin
            dq_s1 <= i_fl_dq;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            if (dq_s2 == dq_s3) dq_q <= dq_s3;
            rb_s1 <= i_ready_busy_out;
            rb_s2 <= rb_s1;
            rb_s3 <= rb_s2;
            if (rb_s2 == rb_s3) rb_q <= rb_s3;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    fcs_state_t state;
    logic [2:0] step, nsteps;
    logic [fcs_pkg::CNT_W-1:0] cnt;
    logic [fcs_pkg::ADDR_W-1:0] addr_q;
    logic [fcs_pkg::DATA_W-1:0] data_q, last_dq;
    logic [2:0] op_q;
    logic first_poll;
    logic [fcs_pkg::ADDR_W-1:0] cyc_addr;
    logic [fcs_pkg::DATA_W-1:0] cyc_data;
    localparam logic [fcs_pkg::CNT_W-1:0] STROBE_END =
        fcs_pkg::CNT_W'(fcs_pkg::STROBE_CYC);
    localparam logic [fcs_pkg::CNT_W-1:0] READ_END =
        fcs_pkg::CNT_W'(fcs_pkg::READ_CYC);
    // Cycle table per op; command cycles carry an 8-bit code only
    always_comb begin
        cyc_addr = fcs_pkg::ADDR_ANY;
        cyc_data = '0;
        nsteps = 3'd0;
        case (op_q)
            fcs_pkg::FCS_OP_PROGRAM: begin
                if (o_bypass) begin
                    nsteps = 3'd2;
                    cyc_data = (step == 3'd0) ? {8'h00, fcs_pkg::CMD_PROG}
                                              : data_q;
                    cyc_addr = (step == 3'd0) ? fcs_pkg::ADDR_ANY : addr_q;
                end else begin
                    nsteps = 3'd4;
                    case (step)
                        3'd0: begin
                            cyc_addr = fcs_pkg::ADDR_UNLOCK1;
                            cyc_data = {8'h00, fcs_pkg::DATA_UNLOCK1};
                        end
                        3'd1: begin
                            cyc_addr = fcs_pkg::ADDR_UNLOCK2;
                            cyc_data = {8'h00, fcs_pkg::DATA_UNLOCK2};
                        end
                        3'd2: begin
                            cyc_addr = fcs_pkg::ADDR_UNLOCK1;
                            cyc_data = {8'h00, fcs_pkg::CMD_PROG};
                        end
                        default: begin
                            cyc_addr = addr_q;
                            cyc_data = data_q;
                        end
                    endcase
                end
            end
            fcs_pkg::FCS_OP_ID_READ, fcs_pkg::FCS_OP_BYP_ENTER: begin
                nsteps = 3'd3;
                case (step)
                    3'd0: begin
                        cyc_addr = fcs_pkg::ADDR_UNLOCK1;
                        cyc_data = {8'h00, fcs_pkg::DATA_UNLOCK1};
                    end
                    3'd1: begin
                        cyc_addr = fcs_pkg::ADDR_UNLOCK2;
                        cyc_data = {8'h00, fcs_pkg::DATA_UNLOCK2};
                    end
                    default: begin
                        cyc_addr = fcs_pkg::ADDR_UNLOCK1;
                        cyc_data = {8'h00,
                            (op_q == fcs_pkg::FCS_OP_ID_READ)
                            ? fcs_pkg::CMD_ID : fcs_pkg::CMD_BYPASS};
                    end
                endcase
            end
            fcs_pkg::FCS_OP_BYP_EXIT: begin
                nsteps = 3'd2;
                cyc_data = {8'h00, (step == 3'd0) ? fcs_pkg::CMD_ID
                                                 : fcs_pkg::CMD_BYP_EXIT2};
            end
            fcs_pkg::FCS_OP_RESET_CMD: begin
                nsteps = 3'd1;
                cyc_data = {8'h00, fcs_pkg::CMD_RESET};
            end
            default: ;
        endcase
    end
    // Only read, program, bypass exit and hardware reset are legal in bypass; others refused
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= FCS_IDLE;
            step <= 3'd0;
            cnt <= '0;
            addr_q <= '0;
            data_q <= '0;
            last_dq <= '0;
            op_q <= 3'd0;
            first_poll <= 1'b0;
            o_ack <= 1'b0;
            o_busy <= 1'b0;
            o_rdata <= '0;
            o_err <= 1'b0;
            o_bypass <= 1'b0;
            o_fl_addr <= '0;
            o_fl_ce_b <= 1'b1;
            o_fl_we_b <= 1'b1;
            o_fl_oe_b <= 1'b1;
            o_fl_reset_b <= 1'b1;
            o_fl_dq <= '0;
            o_fl_dq_oe_b <= 1'b1;
        end else begin
            o_ack <= 1'b0;
            case (state)
                FCS_IDLE: begin
                    if (i_req) begin
                        op_q <= i_op;
                        addr_q <= i_addr;
                        data_q <= i_wdata;
                        step <= 3'd0;
                        cnt <= '0;
                        o_busy <= 1'b1;
                        o_err <= 1'b0;
                        if (i_op == fcs_pkg::FCS_OP_HW_RESET) begin
                            state <= FCS_RSTLOW;
                            o_fl_reset_b <= 1'b0;
                        end else if (i_op == fcs_pkg::FCS_OP_READ) begin
                            state <= FCS_RD;
                        end else if (i_op == fcs_pkg::FCS_OP_PROGRAM ||
                                     i_op == fcs_pkg::FCS_OP_BYP_EXIT ||
                                     !o_bypass) begin
                            state <= FCS_WR;
                        end else begin
                            o_err <= 1'b1;
                            state <= FCS_DONE;
                        end
                    end
                end
                FCS_WR: begin
                    // Ce and we fall together, address set before
                    cnt <= cnt + 1'b1;
                    if (cnt == '0) begin
                        o_fl_addr <= cyc_addr;
                        o_fl_dq <= cyc_data;
                        o_fl_dq_oe_b <= 1'b0;
                    end else if (cnt == 16'd1) begin
                        o_fl_ce_b <= 1'b0;
                        o_fl_we_b <= 1'b0;
                    end else if (cnt == STROBE_END) begin
                        o_fl_ce_b <= 1'b1;
                        o_fl_we_b <= 1'b1;
                    end else if (cnt > STROBE_END) begin
                        o_fl_dq_oe_b <= 1'b1;
                        cnt <= '0;
                        if (step == nsteps - 3'd1) begin
                            step <= 3'd0;
                            if (op_q == fcs_pkg::FCS_OP_PROGRAM) begin
                                state <= FCS_POLL;
                                first_poll <= 1'b1;
                            end else begin
                                if (op_q == fcs_pkg::FCS_OP_BYP_ENTER)
                                    o_bypass <= 1'b1;
                                if (op_q == fcs_pkg::FCS_OP_BYP_EXIT)
                                    o_bypass <= 1'b0;
                                state <= FCS_DONE;
                            end
                        end else begin
                            step <= step + 3'd1;
                        end
                    end
                end
                FCS_RD, FCS_POLL: begin
                    // Sample held long enough for the synchroniser
                    cnt <= cnt + 1'b1;
                    if (cnt == '0) begin
                        o_fl_addr <= addr_q;
                        o_fl_ce_b <= 1'b0;
                        o_fl_oe_b <= 1'b0;
                    end else if (cnt == READ_END) begin
                        o_fl_ce_b <= 1'b1;
                        o_fl_oe_b <= 1'b1;
                        cnt <= '0;
                        last_dq <= dq_q;
                        first_poll <= 1'b0;
                        if (state == FCS_RD) begin
                            o_rdata <= dq_q;
                            state <= FCS_DONE;
                        // Poll match, toggle stopped, or ready
                        end else if (!first_poll &&
                                (dq_q[fcs_pkg::POLL_BIT] ==
                                 data_q[fcs_pkg::POLL_BIT] ||
                                 dq_q[fcs_pkg::TOGGLE_BIT] ==
                                 last_dq[fcs_pkg::TOGGLE_BIT] || rb_q)) begin
                            o_rdata <= dq_q;
                            state <= FCS_DONE;
                        end else if (!first_poll &&
                                     dq_q[fcs_pkg::TIMEOUT_BIT]) begin
                            // Timed out; user must issue a reset command
                            o_rdata <= dq_q;
                            o_err <= 1'b1;
                            state <= FCS_DONE;
                        end
                    end
                end
                FCS_RSTLOW: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= fcs_pkg::CNT_W'(fcs_pkg::RST_LOW_CYC)) begin
                        cnt <= '0;
                        state <= FCS_RSTWAIT;
                    end
                end
                FCS_RSTWAIT: begin
                    // Holding reset low covers the internal reset
                    cnt <= cnt + 1'b1;
                    if (cnt >= fcs_pkg::CNT_W'(READY_WAIT)) begin
                        cnt <= '0;
                        o_fl_reset_b <= 1'b1;
                        o_bypass <= 1'b0;
                        state <= FCS_RSTREC;
                    end
                end
                FCS_RSTREC: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= fcs_pkg::CNT_W'(fcs_pkg::RST_REC_CYC)) begin
                        cnt <= '0;
                        state <= FCS_DONE;
                    end
                end
                FCS_DONE: begin
                    o_ack <= 1'b1;
                    o_busy <= 1'b0;
                    state <= FCS_IDLE;
                end
                default: state <= FCS_IDLE;
            endcase
        end
    end
endmodule

// ### dv/fcs_host_monitor.sv
// Checker on the flash pins of the host controller.
// Assumes bind onto fcs_host; one clock domain.
module fcs_host_monitor #(
    parameter int READY_WAIT = fcs_pkg::READY_WAIT_CYC
) (
    // Watched ports
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        o_ack,
    input wire logic [19:0] o_fl_addr,
    input wire logic        o_fl_ce_b,
    input wire logic        o_fl_we_b,
    input wire logic        o_fl_oe_b,
    input wire logic        o_fl_reset_b,
    input wire logic [15:0] o_fl_dq,
    input wire logic        o_fl_dq_oe_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] low_cnt;
    logic [15:0] hw_cnt;
    logic        hw_on;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Cycles the reset pin has been low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) low_cnt <= 16'h0000;
        else if (o_fl_reset_b) low_cnt <= 16'h0000;
        else low_cnt <= low_cnt + 16'h0001;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) hw_on <= 1'b0;
        else if (!o_fl_reset_b) hw_on <= 1'b1;
        else if (o_ack) hw_on <= 1'b0;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) hw_cnt <= 16'h0000;
        else if (!hw_on) hw_cnt <= 16'h0000;
        else hw_cnt <= hw_cnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_we_low;
        !o_fl_we_b [*3];
    endsequence
    sequence s_no_read;
        o_fl_oe_b [*7];
    endsequence
    property p_we_pulse;
        $fell(o_fl_we_b) |-> s_we_low ##1 o_fl_we_b;
    endproperty
    property p_wr_qual;
        !o_fl_we_b |-> !o_fl_ce_b && o_fl_oe_b && !o_fl_dq_oe_b;
    endproperty
    // Data must survive the rising strobe, where it is latched
    property p_wr_hold;
        !$past(o_fl_we_b) |-> $stable(o_fl_addr) && $stable(o_fl_dq)
            && !o_fl_dq_oe_b;
    endproperty
    property p_cmd_upper;
        !o_fl_we_b && o_fl_addr[10:0] inside {11'h555, 11'h2aa}
            |-> o_fl_dq[15:8] == 8'h00;
    endproperty
    property p_rst_low;
        $rose(o_fl_reset_b) |-> low_cnt >= fcs_pkg::RST_LOW_CYC;
    endproperty
    property p_rst_rec;
        $rose(o_fl_reset_b) |-> s_no_read;
    endproperty
    property p_hw_total;
        o_ack && hw_on |-> hw_cnt >= fcs_pkg::RST_LOW_CYC + READY_WAIT;
    endproperty
    property p_rst_quiet;
        !o_fl_reset_b |-> o_fl_we_b && o_fl_oe_b;
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write strobe width wrong");
    a_wr_qual: assert property (p_wr_qual)
        else $error("write strobe without select");
    a_wr_hold: assert property (p_wr_hold)
        else $error("address or data moved in write");
    a_cmd_upper: assert property (p_cmd_upper)
        else $error("command upper byte not zero");
    a_rst_low: assert property (p_rst_low)
        else $error("reset pin low too short");
    a_rst_rec: assert property (p_rst_rec)
        else $error("read too soon after reset");
    a_hw_total: assert property (p_hw_total)
        else $error("hardware reset finished early");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("strobe active in reset");
endmodule
bind fcs_host fcs_host_monitor #(.READY_WAIT(READY_WAIT))
    fcs_host_monitor_inst (
    .i_clk, .i_rst_b, .o_ack, .o_fl_addr, .o_fl_ce_b, .o_fl_we_b,
    .o_fl_oe_b, .o_fl_reset_b, .o_fl_dq, .o_fl_dq_oe_b);

// ### dv/fcs_flash_model.sv
// Behavioural flash device on the host pins.
// Assumes word mode; program and reset times scaled by parameters.
module fcs_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00c3, // arbitrary value
    parameter logic [15:0] DEV_CODE   = 16'h4a71, // arbitrary value
    parameter int          PROG_NS    = 400,
    parameter int          RST_NS     = 160
) (
    // Pins from host
    input  wire logic [19:0] i_addr,
    input  wire logic        i_ce_b,
    input  wire logic        i_we_b,
    input  wire logic        i_oe_b,
    input  wire logic        i_reset_b,
    input  wire logic [15:0] i_dq,
    // Pins to host
    output logic      [15:0] o_dq,
    output logic             o_ready_busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [19:0]];
    logic [19:0] lat_a;
    logic [15:0] pdat = 16'h0000, rv, last = 16'h0000;
    logic [7:0]  c;
    logic [1:0]  step = 2'd0, pend = 2'd0;
    logic idm = 1'b0, byp = 1'b0, tmo = 1'b0, tog = 1'b0, busy = 1'b0;
    realtime busy_until = 0, rdy_at = 0;
    wire wr_b = i_we_b | i_ce_b;
    ////////////////////////////////////////////////////////////////////////
    task automatic prog(input logic [19:0] a, input logic [15:0] d);
        logic [15:0] old;
        old = mem.exists(a) ? mem[a] : 16'hffff;
        mem[a] = old & d;
        pdat = d;
        pend = 2'd0;
        if ((d & ~old) != 16'h0000) tmo = 1'b1;
        else busy_until = $realtime + PROG_NS;
    endtask
    always @(negedge wr_b) lat_a = i_addr;
    always @(posedge wr_b) begin
        c = i_dq[7:0];
        if (!busy && i_reset_b) begin
            if (pend == 2'd1) prog(lat_a, i_dq);
            else if (byp) begin
                if (pend == 2'd2 && c == 8'h00) byp = 1'b0;
                pend = c == 8'ha0 ? 2'd1 : (c == 8'h90 ? 2'd2 : 2'd0);
            end else if (c == 8'hf0) begin
                idm = 1'b0;
                tmo = 1'b0;
                step = 2'd0;
            end else if (tmo) step = 2'd0;
            else if (step == 2'd0 && c == 8'haa && lat_a[10:0] == 11'h555)
                step = 2'd1; // word mode only, byte mode absent
            else if (step == 2'd1 && c == 8'h55 && lat_a[10:0] == 11'h2aa)
                step = 2'd2;
            else if (step == 2'd2 && lat_a[10:0] == 11'h555) begin
                idm = c == 8'h90;
                byp = c == 8'h20;
                pend = {1'b0, c == 8'ha0};
                step = 2'd0;
            end else step = 2'd0;
        end
    end
    always @(negedge i_oe_b) if (busy || tmo) tog = ~tog;
    // Abort drops the program in flight, cell left as already written
    always @(negedge i_reset_b) begin
        busy_until = 0;
        {tmo, idm, byp, step, pend} = 7'h00;
        rdy_at = $realtime + RST_NS;
    end
    always #1 begin
        busy = $realtime < busy_until;
        o_ready_busy_out = !busy && !tmo && $realtime >= rdy_at;
        if (busy || tmo) rv = {8'h00, ~pdat[7], tog, tmo, 5'h00};
        else if (idm) rv = i_addr[7:0] == 8'h00 ? MAKER_CODE :
            (i_addr[7:0] == 8'h01 ? DEV_CODE : {15'h0, i_addr[12]});
        else rv = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
        if (!i_ce_b && !i_oe_b) last = rv;
        o_dq = (!i_ce_b && !i_oe_b) ? rv : ~last;
    end
endmodule

// ### dv/fcs_host_bench.sv
// Self-checking bench for the flash host controller.
// Assumes fcs_flash_model on the pins and the bound checker.
module fcs_host_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
    localparam logic [15:0] DEVC  = 16'h4a71; // arbitrary value
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0;
    logic [2:0]  i_op = 3'h0;
    logic [19:0] i_addr = 20'h00000, o_fl_addr;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_fl_dq, dev_dq;
    logic o_ack, o_busy, o_err, o_bypass, o_fl_ce_b, o_fl_we_b, o_fl_oe_b;
    logic o_fl_reset_b, o_fl_dq_oe_b, ready;
    int   err_count = 0, compares = 0;
    wire [15:0] i_fl_dq = o_fl_dq_oe_b ? dev_dq : o_fl_dq;
    fcs_host #(.READY_WAIT(20)) fcs_host_inst (.i_clk, .i_rst_b, .i_req,
        .i_op, .i_addr, .i_wdata, .o_ack, .o_busy, .o_rdata, .o_err,
        .o_bypass, .o_fl_addr, .o_fl_ce_b, .o_fl_we_b, .o_fl_oe_b,
        .o_fl_reset_b, .o_fl_dq, .o_fl_dq_oe_b, .i_fl_dq,
        .i_ready_busy_out(ready));
    fcs_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC))
        fcs_flash_model_inst (.i_addr(o_fl_addr), .i_ce_b(o_fl_ce_b),
        .i_we_b(o_fl_we_b), .i_oe_b(o_fl_oe_b), .i_reset_b(o_fl_reset_b),
        .i_dq(i_fl_dq), .o_dq(dev_dq), .o_ready_busy_out(ready));
    initial forever #4 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("counts: mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic ck16(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ck1(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask
    task automatic op(fcs_pkg::fcs_op_t k, logic [19:0] a, logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        {i_req, i_op, i_addr, i_wdata} <= {1'b1, k, a, d};
        @(posedge i_clk);
        i_req <= 1'b0;
        #1;
        ck1("busy", 1'b1, o_busy);
        while (o_ack !== 1'b1 && n < 2000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("unexpected ack: expected 1 seen timeout");
            end_sim;
        end
        ck1("idle", 1'b0, o_busy);
    endtask
    task automatic rd(string n, logic [19:0] a, logic [15:0] e);
        op(fcs_pkg::FCS_OP_READ, a, 16'h0000);
        ck16(n, e, o_rdata);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_program;
        rd("erased", 20'h00100, 16'hffff);
        op(fcs_pkg::FCS_OP_PROGRAM, 20'h01234, 16'h1234);
        ck1("prog err", 1'b0, o_err);
        rd("prog", 20'h01234, 16'h1234);
        op(fcs_pkg::FCS_OP_PROGRAM, 20'h7f000, 16'habcd);
        rd("far prog", 20'h7f000, 16'habcd);
        op(fcs_pkg::FCS_OP_PROGRAM, 20'h01234, 16'h1200);
        rd("clear", 20'h01234, 16'h1200);
        op(fcs_pkg::FCS_OP_PROGRAM, 20'h01234, 16'h00ff);
        ck1("timeout", 1'b1, o_err);
        op(fcs_pkg::FCS_OP_RESET_CMD, 20'h00000, 16'h0000);
        rd("after tmo", 20'h01234, 16'h1200 & 16'h00ff);
    endtask
    task automatic t_ident;
        op(fcs_pkg::FCS_OP_ID_READ, 20'h00000, 16'h0000);
        rd("maker", 20'h00000, MAKER);
        rd("device", 20'h00001, DEVC);
        rd("prot", 20'h01002, 16'h0001);
        rd("unprot", 20'h00002, 16'h0000);
        op(fcs_pkg::FCS_OP_RESET_CMD, 20'h00000, 16'h0000);
        rd("id exit", 20'h00000, 16'hffff);
    endtask
    task automatic t_bypass;
        op(fcs_pkg::FCS_OP_BYP_ENTER, 20'h00000, 16'h0000);
        ck1("bypass", 1'b1, o_bypass);
        op(fcs_pkg::FCS_OP_PROGRAM, 20'h03000, 16'h5a5a);
        rd("byp prog", 20'h03000, 16'h5a5a);
        op(fcs_pkg::FCS_OP_ID_READ, 20'h00000, 16'h0000);
        ck1("refused", 1'b1, o_err);
        op(fcs_pkg::FCS_OP_BYP_EXIT, 20'h00000, 16'h0000);
        ck1("bypass", 1'b0, o_bypass);
        rd("byp exit", 20'h00000, 16'hffff);
    endtask
    task automatic t_hw_reset;
        op(fcs_pkg::FCS_OP_ID_READ, 20'h00000, 16'h0000);
        op(fcs_pkg::FCS_OP_HW_RESET, 20'h00000, 16'h0000);
        ck1("ready", 1'b1, ready);
        rd("hw reset", 20'h00000, 16'hffff);
        rd("kept", 20'h03000, 16'h5a5a);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_program;
        t_ident;
        t_bypass;
        t_hw_reset;
        end_sim;
    end
endmodule
